//--- vhpa_host_port.v
`timescale 1ns/100ps
`include "vhpa_regs.vh"

// Contract
// R1 - Capture host data on write strobe rise
// R2 - Drive data bus only during read strobe
// R3 - Ignore register access while decode enable low
// R4 - Low address for registers, high only memory
// R5 - Read request starts screen RAM read
// R6 - Write request starts screen RAM write
// R7 - Pen strobe fall latches refresh address
// R8 - Address control picks screen bit zero
// R9 - Font bank input selects plane-two bank
// R10 - Mux enables low in alphanumeric modes
// R11 - Display latch strobe on refresh cycles
// R12 - Two eight-bit plane address buses
// R13 - Pixel load strobe in alphanumeric modes
// R14 - Shift load strobe in graphics modes
// R15 - Reset is active high
// R16 - Attribute port pair, indices 0-F palette
// R17 - Indices 10-13 and aliases 30-33
// R18 - Index/data toggle, status read resets
// R19 - Index bit five selects palette source
module vhpa_host_port (
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_host_addr_low,
  input wire [8:0] i_host_addr_high,
  input wire [7:0] i_host_data_bus,
  output reg [7:0] o_host_data_bus,
  output wire o_host_data_bus_oe,
  input wire i_io_decode_enable,
  input wire i_io_read_strobe_n,
  input wire i_io_write_strobe_n,
  input wire i_vid_mem_read_req_n,
  input wire i_vid_mem_write_req_n,
  input wire i_font_bank_select,
  input wire i_addr_bit0_source_sel,
  input wire i_pen_strobe_n,
  input wire [3:0] i_screen_colour_index,
  output wire o_addr_mux_oe_first_n,
  output wire o_addr_mux_oe_second_n,
  output wire o_display_latch_n,
  output reg [7:0] o_upper_plane_addr,
  output reg [7:0] o_lower_plane_addr,
  output wire o_pixel_load_strobe,
  output wire o_shift_load,
  output wire o_mem_cycle_active,
  output wire o_mem_cycle_write,
  output wire o_mem_cycle_done,
  output reg [15:0] o_pen_addr,
  output reg [5:0] o_palette_colour,
  output reg [3:0] o_pixel_pan
);

  // ----------------------------------------
  // Strobe edges
  // ----------------------------------------
  wire wr_rise;
  wire rd_fall;
  wire pen_fall;

  vhpa_edge #(.RISING(1'b1), .IDLE(1'b1)) u_wr_edge (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_level(i_io_write_strobe_n),
    .o_edge(wr_rise)
  );

  vhpa_edge #(.RISING(1'b0), .IDLE(1'b1)) u_rd_edge (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_level(i_io_read_strobe_n),
    .o_edge(rd_fall)
  );

  vhpa_edge #(.RISING(1'b0), .IDLE(1'b1)) u_pen_edge (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_level(i_pen_strobe_n),
    .o_edge(pen_fall)
  );

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Upper address lines never enter this decode
  wire hit_index = i_io_decode_enable && (i_host_addr_low == `VHPA_PORT_ATTR_INDEX); // R3 R4
  wire hit_data = i_io_decode_enable && (i_host_addr_low == `VHPA_PORT_ATTR_DATA); // R3 R4 R16
  wire hit_status = i_io_decode_enable && (i_host_addr_low == `VHPA_PORT_INPUT_STATUS); // R3 R4
  wire hit_pen_clr = i_io_decode_enable && (i_host_addr_low == `VHPA_PORT_PEN_CLEAR); // R3
  wire hit_pen_set = i_io_decode_enable && (i_host_addr_low == `VHPA_PORT_PEN_SET); // R3
  wire hit_any_read = hit_index || hit_data || hit_status;

  // ----------------------------------------
  // Attribute registers
  // ----------------------------------------
  reg data_phase_r;
  reg [5:0] index_r;
  reg [5:0] palette_r [0:15];
  reg [3:0] mode_r;
  reg [5:0] border_r;
  reg [3:0] plane_en_r;
  reg [3:0] pan_r;
  reg sel_palette;
  reg sel_mode;
  reg sel_border;
  reg sel_plane_en;
  reg sel_pan;
  integer k;

  wire [4:0] index_addr = index_r[`VHPA_INDEX_ADDR_MSB:0];
  wire screen_source = index_r[`VHPA_INDEX_SRC_BIT];
  wire graphics_mode = mode_r[`VHPA_MODE_GRAPHICS_BIT];

  always @* begin
    sel_palette = (index_addr <= `VHPA_IDX_PALETTE_LAST); // R16
    // Bit five doubles as the alias bit for 30-33
    sel_mode = (index_addr == `VHPA_IDX_MODE); // R17
    sel_border = (index_addr == `VHPA_IDX_BORDER); // R17
    sel_plane_en = (index_addr == `VHPA_IDX_PLANE_EN); // R17
    sel_pan = (index_addr == `VHPA_IDX_PAN); // R17
  end

  wire wr_index = wr_rise && (hit_index || hit_data) && !data_phase_r;
  wire wr_data = wr_rise && (hit_index || hit_data) && data_phase_r;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin // R15
      data_phase_r <= 1'b0;
      index_r <= `VHPA_RST_INDEX;
      mode_r <= `VHPA_RST_MODE;
      border_r <= `VHPA_RST_BORDER;
      plane_en_r <= `VHPA_RST_PLANE_EN;
      pan_r <= `VHPA_RST_PAN;
      for (k = 0; k < 16; k = k + 1) begin
        palette_r[k] <= `VHPA_RST_PALETTE;
      end
    end else begin
      if (rd_fall && hit_status) begin
        data_phase_r <= 1'b0; // R18
      end else if (wr_index || wr_data) begin
        data_phase_r <= ~data_phase_r; // R18
      end
      if (wr_index) begin
        index_r <= i_host_data_bus[5:0]; // R1
      end
      if (wr_data) begin // R1
        // Host palette loads only while the screen is off the palette
        if (sel_palette && !screen_source) begin // R19
          palette_r[index_addr[3:0]] <= i_host_data_bus[5:0];
        end
        if (sel_mode) begin
          mode_r <= i_host_data_bus[3:0];
        end
        if (sel_border) begin
          border_r <= i_host_data_bus[5:0];
        end
        if (sel_plane_en) begin
          plane_en_r <= i_host_data_bus[3:0];
        end
        if (sel_pan) begin
          pan_r <= i_host_data_bus[3:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Display refresh slots
  // ----------------------------------------
  reg [3:0] slot_r;
  reg [15:0] refresh_addr_r;

  // Refresh address advances once per character period
  wire slot_end = (slot_r == (`VHPA_CHAR_CYCLES - 4'h1));
  wire refresh_slot = (slot_r == 4'h0);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      slot_r <= 4'h0;
      refresh_addr_r <= 16'h0000;
    end else begin
      slot_r <= slot_end ? 4'h0 : slot_r + 4'h1;
      if (slot_end) begin
        refresh_addr_r <= refresh_addr_r + 16'h0001;
      end
    end
  end

  assign o_display_latch_n = ~(slot_r == `VHPA_LATCH_SLOT); // R11
  wire load_slot = (slot_r == `VHPA_LOAD_SLOT);
  assign o_pixel_load_strobe = ~(load_slot && !graphics_mode); // R13
  assign o_shift_load = ~(load_slot && graphics_mode); // R14

  // ----------------------------------------
  // Host screen memory cycles
  // ----------------------------------------
  wire rd_req = ~i_vid_mem_read_req_n;
  wire wr_req = ~i_vid_mem_write_req_n;
  wire seq_busy;
  wire seq_col;
  reg req_seen_r;
  reg [16:0] host_addr_r;

  // A held request starts one cycle only; none starts in the refresh slot
  wire mem_start = (rd_req || wr_req) && !req_seen_r && !seq_busy && !refresh_slot; // R5 R6

  // Both requests low count as a write
  vhpa_mem_seq u_mem_seq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(mem_start),
    .i_write(wr_req),
    .o_busy(seq_busy),
    .o_col_phase(seq_col),
    .o_write(o_mem_cycle_write),
    .o_done(o_mem_cycle_done)
  );

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      req_seen_r <= 1'b0;
      host_addr_r <= 17'h00000;
    end else begin
      if (!rd_req && !wr_req) begin
        req_seen_r <= 1'b0;
      end else if (mem_start) begin
        req_seen_r <= 1'b1;
      end
      if (mem_start) begin
        host_addr_r <= {i_host_addr_high, i_host_addr_low}; // R4
      end
    end
  end

  assign o_mem_cycle_active = seq_busy;

  // Bit zero comes from A0 or, for chained planes, from A16
  wire host_bit0 = i_addr_bit0_source_sel ? host_addr_r[0] : host_addr_r[16]; // R8
  wire [7:0] host_row = {host_addr_r[7:1], host_bit0};
  wire [7:0] host_col = host_addr_r[15:8];
  wire [7:0] ref_row = refresh_addr_r[7:0];
  wire [7:0] ref_col = refresh_addr_r[15:8];
  wire alpha_refresh = !seq_busy && !graphics_mode;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lower_plane_addr <= 8'h00;
      o_upper_plane_addr <= 8'h00;
    end else begin
      if (seq_busy) begin // R12
        o_lower_plane_addr <= seq_col ? host_col : host_row;
        o_upper_plane_addr <= seq_col ? host_col : host_row;
      end else begin
        o_lower_plane_addr <= slot_r[0] ? ref_col : ref_row;
        // Font plane bank steers the top plane-two address bit
        o_upper_plane_addr <= slot_r[0] ? {i_font_bank_select, ref_col[6:0]} : ref_row; // R9 R12
      end
    end
  end

  // External latches own the plane 2/3 bus during text refresh
  assign o_addr_mux_oe_first_n = ~alpha_refresh; // R10
  assign o_addr_mux_oe_second_n = ~alpha_refresh; // R10

  // ----------------------------------------
  // Light pen latch
  // ----------------------------------------
  reg pen_held_r;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pen_held_r <= 1'b0;
      o_pen_addr <= 16'h0000;
    end else begin
      // Set wins over a clear in the same cycle
      if ((pen_fall || (wr_rise && hit_pen_set)) && (!pen_held_r || (wr_rise && hit_pen_clr))) begin
        pen_held_r <= 1'b1;
        o_pen_addr <= refresh_addr_r; // R7
      end else if (wr_rise && hit_pen_clr) begin
        pen_held_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Palette lookup
  // ----------------------------------------
  // Disabled planes force their index bit to zero
  wire [3:0] masked_index = i_screen_colour_index & plane_en_r;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_palette_colour <= 6'h00;
      o_pixel_pan <= 4'h0;
    end else begin
      // While the host owns the palette the screen shows border
      o_palette_colour <= screen_source ? palette_r[masked_index] : border_r; // R19
      o_pixel_pan <= pan_r;
    end
  end

  // ----------------------------------------
  // Host read data
  // ----------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    if (hit_index) begin
      rd_mux = {2'b00, index_r};
    end else if (hit_data) begin
      // Mode control is write-only and reads as zero
      if (sel_palette) begin
        rd_mux = {2'b00, palette_r[index_addr[3:0]]};
      end else if (sel_border) begin
        rd_mux = {2'b00, border_r};
      end else if (sel_plane_en) begin
        rd_mux = {4'h0, plane_en_r};
      end else if (sel_pan) begin
        rd_mux = {4'h0, pan_r};
      end
    end else if (hit_status) begin
      rd_mux[`VHPA_STATUS_REFRESH_BIT] = refresh_slot;
      rd_mux[`VHPA_STATUS_PEN_BIT] = pen_held_r;
      rd_mux[`VHPA_STATUS_HOSTMEM_BIT] = seq_busy;
    end
  end

  // Data lags the strobe by one cycle; enable is immediate
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_data_bus <= 8'h00;
    end else begin
      o_host_data_bus <= rd_mux;
    end
  end

  assign o_host_data_bus_oe = ~i_io_read_strobe_n && hit_any_read; // R2 R3

endmodule // vhpa_host_port

//--- vhpa_regs.vh
`ifndef VHPA_REGS_VH
`define VHPA_REGS_VH

// ----------------------------------------
// Port offsets on the low address byte
// ----------------------------------------
`define VHPA_PORT_ATTR_INDEX 8'hc0
`define VHPA_PORT_ATTR_DATA 8'hc1
`define VHPA_PORT_INPUT_STATUS 8'hda
`define VHPA_PORT_PEN_CLEAR 8'hdb
`define VHPA_PORT_PEN_SET 8'hdc

// ----------------------------------------
// Attribute index values
// ----------------------------------------
`define VHPA_IDX_PALETTE_LAST 5'h0f
`define VHPA_IDX_MODE 5'h10
`define VHPA_IDX_BORDER 5'h11
`define VHPA_IDX_PLANE_EN 5'h12
`define VHPA_IDX_PAN 5'h13
`define VHPA_IDX_ALIAS_BIT 5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VHPA_INDEX_ADDR_MSB 4
`define VHPA_INDEX_SRC_BIT 5
`define VHPA_MODE_GRAPHICS_BIT 0
`define VHPA_STATUS_REFRESH_BIT 0
`define VHPA_STATUS_PEN_BIT 2
`define VHPA_STATUS_HOSTMEM_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VHPA_RST_INDEX 6'h00
`define VHPA_RST_PALETTE 6'h00
`define VHPA_RST_MODE 4'h0
`define VHPA_RST_BORDER 6'h00
`define VHPA_RST_PLANE_EN 4'hf
`define VHPA_RST_PAN 4'h0

// ----------------------------------------
// Timing counts in clock cycles
// ----------------------------------------
`define VHPA_CHAR_CYCLES 4'h8
`define VHPA_LATCH_SLOT 4'h1
`define VHPA_LOAD_SLOT 4'h7

`endif

//--- vhpa_edge.v
`timescale 1ns/100ps

module vhpa_edge #(
  parameter RISING = 1'b1,
  parameter IDLE = 1'b1
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_level,
  output wire o_edge
);

  reg prev_r;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_r <= IDLE;
    end else begin
      prev_r <= i_level;
    end
  end

  assign o_edge = RISING ? (i_level & ~prev_r) : (~i_level & prev_r);

endmodule // vhpa_edge

//--- vhpa_mem_seq.v
`timescale 1ns/100ps

module vhpa_mem_seq (
  input wire i_clk,
  input wire i_rst,
  input wire i_start,
  input wire i_write,
  output wire o_busy,
  output wire o_col_phase,
  output reg o_write,
  output wire o_done
);

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ROW = 2'b01;
  localparam [1:0] ST_COL = 2'b10;
  localparam [1:0] ST_DONE = 2'b11;

  reg [1:0] state_r;
  reg [1:0] state_nxt;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (i_start) begin
          state_nxt = ST_ROW;
        end
      end
      ST_ROW: state_nxt = ST_COL;
      ST_COL: state_nxt = ST_DONE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      o_write <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && i_start) begin
        o_write <= i_write;
      end
    end
  end

  assign o_busy = (state_r != ST_IDLE);
  assign o_col_phase = (state_r == ST_COL) || (state_r == ST_DONE);
  assign o_done = (state_r == ST_DONE);

endmodule // vhpa_mem_seq

//--- vhpa_props.sv
`timescale 1ns/100ps
module vhpa_props (
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_host_addr_low,
  input wire i_io_decode_enable,
  input wire i_io_read_strobe_n,
  input wire o_host_data_bus_oe,
  input wire o_addr_mux_oe_first_n,
  input wire o_addr_mux_oe_second_n,
  input wire o_display_latch_n,
  input wire o_pixel_load_strobe,
  input wire o_shift_load,
  input wire o_mem_cycle_active,
  input wire o_mem_cycle_done
);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_mem_steps;
    o_mem_cycle_active && !o_mem_cycle_done ##1 o_mem_cycle_active && !o_mem_cycle_done
      ##1 o_mem_cycle_active && o_mem_cycle_done;
  endsequence
  sequence s_char_gap;
    o_display_latch_n [*7] ##1 !o_display_latch_n;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_oe_needs_read: assert property (o_host_data_bus_oe |-> !i_io_read_strobe_n && i_io_decode_enable)
    else $error("data bus driven without read strobe");
  a_oe_attr_port: assert property (!i_io_read_strobe_n && i_io_decode_enable && i_host_addr_low == 8'hc1
    |-> o_host_data_bus_oe)
    else $error("attribute data read not driven");
  a_decode_gate: assert property (!i_io_decode_enable |-> !o_host_data_bus_oe)
    else $error("bus driven with decode low");
  a_mem_three_cycles: assert property ($rose(o_mem_cycle_active) |-> s_mem_steps)
    else $error("memory cycle shape wrong");
  a_latch_period: assert property ($fell(o_display_latch_n) |=> s_char_gap)
    else $error("display latch period wrong");
  a_load_after_latch: assert property (!o_pixel_load_strobe || !o_shift_load |-> !$past(o_display_latch_n, 6))
    else $error("load strobe not six cycles after latch");
  a_load_exclusive: assert property (!(!o_pixel_load_strobe && !o_shift_load))
    else $error("both load strobes low");
  a_mux_pair: assert property (o_addr_mux_oe_first_n == o_addr_mux_oe_second_n)
    else $error("mux enables differ");
  a_mux_host_off: assert property (o_mem_cycle_active || !o_shift_load |-> o_addr_mux_oe_first_n)
    else $error("mux enabled in host cycle or graphics");
endmodule // vhpa_props

//--- vhpa_host_model.sv
`timescale 1ns/100ps
module vhpa_host_model (
  input wire i_clk,
  input wire [7:0] i_dev_data,
  input wire i_dev_oe,
  output wire [7:0] o_bus
);
  reg [7:0] float_r = 8'h5a;
  // Released bus toggles so a stale read value cannot pass
  always @(posedge i_clk) begin
    float_r <= ~o_bus;
  end
  assign o_bus = i_dev_oe ? i_dev_data : float_r;
endmodule // vhpa_host_model

//--- vhpa_host_port_tb.sv
`timescale 1ns/100ps
module vhpa_host_port_tb;
  typedef struct packed {logic [7:0] widx; logic [7:0] wdat; logic [7:0] ridx; logic [7:0] exp;} vhpa_row_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_host_addr_low = 8'h00;
  logic [8:0] i_host_addr_high = 9'h1ff;
  logic [7:0] i_host_data_bus = 8'h00;
  logic i_io_decode_enable = 1'b1;
  logic i_io_read_strobe_n = 1'b1;
  logic i_io_write_strobe_n = 1'b1;
  logic i_vid_mem_read_req_n = 1'b1;
  logic i_vid_mem_write_req_n = 1'b1;
  logic i_font_bank_select = 1'b0;
  logic i_addr_bit0_source_sel = 1'b1;
  logic i_pen_strobe_n = 1'b1;
  logic [3:0] i_screen_colour_index = 4'hf;
  wire [7:0] o_host_data_bus, o_upper_plane_addr, o_lower_plane_addr, bus_w;
  wire o_host_data_bus_oe, o_addr_mux_oe_first_n, o_addr_mux_oe_second_n, o_display_latch_n;
  wire o_pixel_load_strobe, o_shift_load, o_mem_cycle_active, o_mem_cycle_write, o_mem_cycle_done;
  wire [15:0] o_pen_addr;
  wire [5:0] o_palette_colour;
  wire [3:0] o_pixel_pan;
  int n_mismatch = 0;
  int checked = 0;
  int n, np, ns, nl, nm;
  logic [7:0] d, a;
  logic oe, w;
  logic [15:0] p1;
  vhpa_row_t rows [0:8] = '{'{8'h00, 8'hff, 8'h00, 8'h3f}, '{8'h0a, 8'h3c, 8'h0a, 8'h3c},
    '{8'h0f, 8'h2a, 8'h0f, 8'h2a}, '{8'h11, 8'h15, 8'h11, 8'h15}, '{8'h32, 8'h0a, 8'h12, 8'h0a},
    '{8'h13, 8'h07, 8'h13, 8'h07}, '{8'h14, 8'h55, 8'h14, 8'h00}, '{8'h25, 8'h11, 8'h05, 8'h00},
    '{8'h30, 8'h01, 8'h10, 8'h00}};

  vhpa_host_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_host_addr_low(i_host_addr_low),
    .i_host_addr_high(i_host_addr_high), .i_host_data_bus(i_host_data_bus), .o_host_data_bus(o_host_data_bus),
    .o_host_data_bus_oe(o_host_data_bus_oe), .i_io_decode_enable(i_io_decode_enable),
    .i_io_read_strobe_n(i_io_read_strobe_n), .i_io_write_strobe_n(i_io_write_strobe_n),
    .i_vid_mem_read_req_n(i_vid_mem_read_req_n), .i_vid_mem_write_req_n(i_vid_mem_write_req_n),
    .i_font_bank_select(i_font_bank_select), .i_addr_bit0_source_sel(i_addr_bit0_source_sel),
    .i_pen_strobe_n(i_pen_strobe_n), .i_screen_colour_index(i_screen_colour_index),
    .o_addr_mux_oe_first_n(o_addr_mux_oe_first_n), .o_addr_mux_oe_second_n(o_addr_mux_oe_second_n),
    .o_display_latch_n(o_display_latch_n), .o_upper_plane_addr(o_upper_plane_addr),
    .o_lower_plane_addr(o_lower_plane_addr), .o_pixel_load_strobe(o_pixel_load_strobe),
    .o_shift_load(o_shift_load), .o_mem_cycle_active(o_mem_cycle_active), .o_mem_cycle_write(o_mem_cycle_write),
    .o_mem_cycle_done(o_mem_cycle_done), .o_pen_addr(o_pen_addr), .o_palette_colour(o_palette_colour),
    .o_pixel_pan(o_pixel_pan));
  vhpa_host_model model_u (.i_clk(i_clk), .i_dev_data(o_host_data_bus), .i_dev_oe(o_host_data_bus_oe), .o_bus(bus_w));

  always #12.5 i_clk = ~i_clk;

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic io_wr(input logic [7:0] ad, input logic [7:0] dt, input logic dec = 1'b1);
    @(posedge i_clk);
    i_host_addr_low <= ad;
    i_host_data_bus <= dt;
    i_io_decode_enable <= dec;
    i_io_write_strobe_n <= 1'b0;
    @(posedge i_clk);
    i_io_write_strobe_n <= 1'b1;
    @(posedge i_clk);
  endtask

  task automatic io_rd(input logic [7:0] ad, output logic [7:0] dt, output logic en, input logic dec = 1'b1);
    @(posedge i_clk);
    i_host_addr_low <= ad;
    i_io_decode_enable <= dec;
    i_io_read_strobe_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    dt = bus_w;
    en = o_host_data_bus_oe;
    i_io_read_strobe_n <= 1'b1;
    @(posedge i_clk);
  endtask

  task automatic mem_req(input logic wr, output logic [7:0] ra, output logic rw, output int rises);
    int t;
    logic p;
    @(posedge i_clk);
    i_host_addr_low <= 8'h5a;
    i_host_addr_high <= 9'h100;
    i_addr_bit0_source_sel <= !wr;
    if (wr) i_vid_mem_write_req_n <= 1'b0;
    else i_vid_mem_read_req_n <= 1'b0;
    t = 0;
    do begin
      @(posedge i_clk);
      t++;
    end while (!o_mem_cycle_active && t < 16);
    @(posedge i_clk);
    ra = o_lower_plane_addr;
    rw = o_mem_cycle_write;
    rises = 0;
    p = 1'b1;
    repeat (20) begin
      @(posedge i_clk);
      rises += (o_mem_cycle_active && !p) + 2 * o_mem_cycle_done;
      p = o_mem_cycle_active;
    end
    i_vid_mem_read_req_n <= 1'b1;
    i_vid_mem_write_req_n <= 1'b1;
    @(posedge i_clk);
  endtask

  task automatic watch(output int cp, output int cs, output int cl, output int cm);
    cp = 0;
    cs = 0;
    cl = 0;
    cm = 0;
    repeat (16) begin
      @(posedge i_clk);
      cp += !o_pixel_load_strobe;
      cs += !o_shift_load;
      cl += !o_display_latch_n;
      cm += !o_addr_mux_oe_first_n;
    end
  endtask

  task automatic pen_pulse;
    @(posedge i_clk);
    i_pen_strobe_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_pen_strobe_n <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask

  // ----------------------------------------
  // Sequence of tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge i_clk);
    chk({o_pen_addr, o_pixel_pan, o_palette_colour, o_mem_cycle_active}, 32'h0);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      io_rd(8'hda, d, oe);
      io_wr(8'hc0, rows[i].widx);
      io_wr(8'hc1, rows[i].wdat);
      io_wr(8'hc0, rows[i].ridx);
      io_rd(8'hc1, d, oe);
      chk({oe, d}, {1'b1, rows[i].exp});
    end
    chk({o_palette_colour, o_pixel_pan}, {6'h15, 4'h7});
    watch(np, ns, nl, nm);
    chk({np[3:0], ns[3:0], nl[3:0], 3'h0, nm == 16}, 16'h0220);
    io_rd(8'hda, d, oe);
    io_wr(8'hc0, 8'h10);
    io_wr(8'hc1, 8'h00);
    watch(np, ns, nl, nm);
    chk({np[3:0], ns[3:0], nl[3:0], 3'h0, nm == 16}, 16'h2021);
    i_font_bank_select <= 1'b1;
    repeat (2) @(posedge i_clk);
    n = 0;
    repeat (16) begin
      @(posedge i_clk);
      n += (o_upper_plane_addr != o_lower_plane_addr);
    end
    chk(n, 8);
    io_rd(8'hda, d, oe);
    io_wr(8'hc0, 8'h20);
    repeat (3) @(posedge i_clk);
    chk(o_palette_colour, 6'h3c);
    i_screen_colour_index <= 4'h5;
    repeat (2) @(posedge i_clk);
    chk(o_palette_colour, 6'h3f);
    io_wr(8'hc0, 8'h11);
    io_wr(8'hc0, 8'h31);
    io_rd(8'hda, d, oe);
    io_wr(8'hc1, 8'h12);
    io_wr(8'hc1, 8'h05);
    io_wr(8'hc0, 8'h12);
    io_rd(8'hc1, d, oe);
    chk(d, 8'h05);
    io_rd(8'hda, d, oe);
    io_wr(8'hc0, 8'h13, 1'b0);
    io_wr(8'hc1, 8'h0f, 1'b0);
    io_rd(8'hc1, d, oe, 1'b0);
    chk(oe, 1'b0);
    io_wr(8'hc0, 8'h13);
    io_rd(8'hc1, d, oe);
    chk(d, 8'h07);
    io_rd(8'h55, d, oe);
    chk(oe, 1'b0);
    for (int k = 0; k < 2; k++) begin
      mem_req(k[0], a, w, n);
      chk({a, w, 3'h0, n[3:0]}, {8'h5a + 8'(k), k[0], 7'h02});
    end
    io_wr(8'hdb, 8'h00);
    pen_pulse;
    p1 = o_pen_addr;
    chk(p1 != 16'h0, 1'b1);
    io_rd(8'hda, d, oe);
    chk(d[2], 1'b1);
    pen_pulse;
    chk(o_pen_addr, p1);
    io_wr(8'hdb, 8'h00);
    pen_pulse;
    chk(o_pen_addr != p1, 1'b1);
    io_wr(8'hdb, 8'h00);
    io_rd(8'hda, d, oe);
    chk(d[2], 1'b0);
    io_wr(8'hdc, 8'h00);
    io_rd(8'hda, d, oe);
    chk(d[2], 1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk({o_pen_addr, o_pixel_pan, o_palette_colour, o_mem_cycle_active}, 32'h0);
    i_rst <= 1'b0;
    io_rd(8'hda, d, oe);
    io_wr(8'hc0, 8'h12);
    io_rd(8'hc1, d, oe);
    chk(d, 8'h0f);
    conclude;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    conclude;
  end
endmodule // vhpa_host_port_tb

bind vhpa_host_port vhpa_props props_u (.i_clk(i_clk), .i_rst(i_rst), .i_host_addr_low(i_host_addr_low),
  .i_io_decode_enable(i_io_decode_enable), .i_io_read_strobe_n(i_io_read_strobe_n),
  .o_host_data_bus_oe(o_host_data_bus_oe), .o_addr_mux_oe_first_n(o_addr_mux_oe_first_n),
  .o_addr_mux_oe_second_n(o_addr_mux_oe_second_n), .o_display_latch_n(o_display_latch_n),
  .o_pixel_load_strobe(o_pixel_load_strobe), .o_shift_load(o_shift_load),
  .o_mem_cycle_active(o_mem_cycle_active), .o_mem_cycle_done(o_mem_cycle_done));
